// File: design/ldev_cfg_defines.svh
// constants for the logical device resource configuration block
// assumes inclusion by bare name from the package and modules
`ifndef LDEV_CFG_DEFINES_SVH
`define LDEV_CFG_DEFINES_SVH
`define NUM_BANKS        9
`define BANK_W           4
`define SLOT_W           2
`define MEM_ADDR_W       6
`define PORT_INDEX       1'b0
`define PORT_DATA        1'b1
`define IDX_LDN          8'h07
`define IDX_BANKED_MIN   8'h30
`define IDX_IO_BASE0_HI  8'h60
`define IDX_IO_BASE0_LO  8'h61
`define IDX_IO_BASE1_HI  8'h62
`define IDX_IO_BASE1_LO  8'h63
`define IDX_IRQ_SEL      8'h70
`define IDX_IRQ_TYPE     8'h71
`define IDX_DMA0         8'h74
`define IDX_DMA1         8'h75
`define DMA_NONE         8'h04
`define ZERO_BYTE        8'h00
`define IRQ_NUM_W        4
`define IRQ_LINES        16
`define IRQ_NONE         4'h0
`define WAKE_BIT         4
`define POL_BIT          1
`define LVL_BIT          0
`define IRQ_SEL_MASK     8'h1F
`define IRQ_TYPE_MASK    8'h03
`define IRQ_TYPE_RST     2'h2
`define EDGE_ONLY_BANKS  9'h000
`define LEVEL_ONLY_BANKS 9'h000
`endif

// File: design/ldev_cfg_pkg.sv
// types shared by the logical device configuration block
// assumes the defines header is on the include path
package ldev_cfg_pkg;
`include "ldev_cfg_defines.svh"
    typedef logic [7:0]                   byte_t;
    typedef logic [`BANK_W-1:0]           bank_t;
    typedef logic [`IRQ_NUM_W-1:0]        irq_num_t;
    typedef logic [`IRQ_LINES-1:0]        irq_vec_t;
    typedef logic [`NUM_BANKS-1:0]        bank_vec_t;
    typedef logic [`MEM_ADDR_W-1:0]       mem_addr_t;
endpackage

// File: design/ldev_base_mem.sv
// small memory holding the i/o base descriptor bytes of every bank
// assumes one access per cycle; read data comes out of a register
`timescale 1ns/100ps
`include "ldev_cfg_defines.svh"
module ldev_base_mem
    import ldev_cfg_pkg::*;
(
    input  wire logic                core_clk_in,  // device clock
    input  wire logic                reset_in,     // sync reset, active high
    input  wire logic                wr_en_in,     // write strobe
    input  wire ldev_cfg_pkg::mem_addr_t addr_in,  // bank and slot
    input  wire ldev_cfg_pkg::byte_t wdata_in,     // write data
    output ldev_cfg_pkg::byte_t      rdata_out     // registered read data
);
    import ldev_cfg_pkg::*;

    localparam int DEPTH = `NUM_BANKS << `SLOT_W;

    byte_t mem_q [DEPTH];
    byte_t rdata_q;

    assign rdata_out = rdata_q;

    // reset clears all descriptors so no resource is assigned by default
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= `ZERO_BYTE;
            end
            rdata_q <= `ZERO_BYTE;
        end else begin
            if (wr_en_in && (int'(addr_in) < DEPTH)) begin
                mem_q[addr_in] <= wdata_in;
            end
            rdata_q <= (int'(addr_in) < DEPTH) ? mem_q[addr_in] : `ZERO_BYTE;
        end
    end
endmodule

// File: design/ldev_cfg_regs.sv
// banked resource configuration registers behind the index-data port
// assumes host strobes are single-cycle and synchronous to core_clk_in
`timescale 1ns/100ps
`include "ldev_cfg_defines.svh"
module ldev_cfg_regs
    import ldev_cfg_pkg::*;
(
    input  wire logic                    core_clk_in,    // device clock, 250 MHz
    input  wire logic                    reset_in,       // sync reset, active high
    input  wire logic                    cfg_wr_in,      // host write strobe
    input  wire logic                    cfg_rd_in,      // host read strobe
    input  wire logic                    cfg_port_in,    // 0 index, 1 data
    input  wire ldev_cfg_pkg::byte_t     cfg_wdata_in,   // host write data
    output ldev_cfg_pkg::byte_t          cfg_rdata_out,  // host read data
    output logic                         cfg_rvalid_out, // read data valid pulse
    input  wire ldev_cfg_pkg::bank_vec_t dev_irq_in,     // device requests, high
    output ldev_cfg_pkg::bank_vec_t      irq_power_event_out, // wake event pulses
    output ldev_cfg_pkg::irq_vec_t       irq_req_out,    // line asserted
    output ldev_cfg_pkg::irq_vec_t       irq_pol_out,    // line polarity, 1 high
    output ldev_cfg_pkg::irq_vec_t       irq_level_out   // line type, 1 level
);
    import ldev_cfg_pkg::*;

    // slot of an io base index within a bank, flag set when it is one
    function automatic logic [`SLOT_W:0] io_slot(input byte_t idx);
        unique case (idx)
            `IDX_IO_BASE0_HI: io_slot = {1'b1, 2'h0};
            `IDX_IO_BASE0_LO: io_slot = {1'b1, 2'h1};
            `IDX_IO_BASE1_HI: io_slot = {1'b1, 2'h2};
            `IDX_IO_BASE1_LO: io_slot = {1'b1, 2'h3};
            default:          io_slot = {1'b0, 2'h0};
        endcase
    endfunction

    // bit of a per-bank mask; device numbers without a bank read as clear
    function automatic logic bank_bit(input bank_vec_t mask, input bank_t b);
        bank_bit = (int'(b) < `NUM_BANKS) ? mask[b] : 1'b0;
    endfunction

    byte_t     index_q;
    bank_t     ldn_q;
    irq_num_t  irq_num_q [`NUM_BANKS];
    bank_vec_t wake_en_q;
    bank_vec_t pol_q;
    bank_vec_t lvl_q;
    bank_vec_t irq_prev_q;
    bank_vec_t event_q;
    irq_vec_t  req_q;
    irq_vec_t  pol_line_q;
    irq_vec_t  lvl_line_q;
    byte_t     hold_q;
    logic      from_mem_q;
    logic      rd_pend_q;
    byte_t     rdata_q;
    logic      rvalid_q;
    byte_t     mem_rdata;

    wire data_wr    = cfg_wr_in && (cfg_port_in == `PORT_DATA);
    wire data_rd    = cfg_rd_in && (cfg_port_in == `PORT_DATA);
    wire index_wr   = cfg_wr_in && (cfg_port_in == `PORT_INDEX);
    wire index_rd   = cfg_rd_in && (cfg_port_in == `PORT_INDEX);
    // reserved device numbers have no bank, so banked accesses fall through
    wire bank_ok    = int'(ldn_q) < `NUM_BANKS;
    wire banked     = (index_q >= `IDX_BANKED_MIN) && bank_ok;
    wire [`SLOT_W:0] slot = io_slot(index_q);
    wire hit_io     = banked && slot[`SLOT_W];
    wire hit_sel    = banked && (index_q == `IDX_IRQ_SEL);
    wire hit_type   = banked && (index_q == `IDX_IRQ_TYPE);
    wire hit_dma    = banked && ((index_q == `IDX_DMA0) || (index_q == `IDX_DMA1));
    wire hit_ldn    = index_q == `IDX_LDN;

    wire mem_wr     = data_wr && hit_io;
    wire mem_addr_t mem_addr = {ldn_q, slot[`SLOT_W-1:0]};

    localparam bank_vec_t  EDGE_MASK  = `EDGE_ONLY_BANKS;
    localparam bank_vec_t  LEVEL_MASK = `LEVEL_ONLY_BANKS;
    localparam logic [1:0] TYPE_RST   = `IRQ_TYPE_RST;

    // a single-type bank pins its type bit, so writes to it are dropped
    wire edge_only  = bank_bit(EDGE_MASK, ldn_q);
    wire level_only = bank_bit(LEVEL_MASK, ldn_q);
    wire ro_type    = edge_only || level_only;
    wire ro_type_v  = level_only;

    ldev_base_mem u_base_mem (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .wr_en_in    (mem_wr),
        .addr_in     (mem_addr),
        .wdata_in    (cfg_wdata_in),
        .rdata_out   (mem_rdata)
    );

    // read value for every non-memory register; reserved bits stay zero
    wire byte_t sel_rd  = {3'h0, wake_en_q[ldn_q], irq_num_q[ldn_q]};
    wire byte_t type_rd = {6'h00, pol_q[ldn_q], lvl_q[ldn_q]};
    wire byte_t reg_rd  = index_rd ? index_q :
                          hit_ldn  ? {4'h0, ldn_q} :
                          hit_sel  ? sel_rd :
                          hit_type ? type_rd :
                          hit_dma  ? `DMA_NONE :
                                     `ZERO_BYTE;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            index_q <= `ZERO_BYTE;
            ldn_q   <= '0;
        end else begin
            if (index_wr) begin
                index_q <= cfg_wdata_in;
            end
            if (data_wr && hit_ldn) begin
                ldn_q <= cfg_wdata_in[`BANK_W-1:0];
            end
        end
    end

    // interrupt configuration of every bank is flops, needed in parallel
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            for (int b = 0; b < `NUM_BANKS; b++) begin
                irq_num_q[b] <= `IRQ_NONE;
            end
            wake_en_q <= '0;
            for (int b = 0; b < `NUM_BANKS; b++) begin
                pol_q[b] <= TYPE_RST[`POL_BIT];
                // a level-only bank comes up level, an edge-only bank edge
                lvl_q[b] <= bank_bit(LEVEL_MASK, bank_t'(b)) |
                            (TYPE_RST[`LVL_BIT] & !bank_bit(EDGE_MASK, bank_t'(b)));
            end
        end else begin
            if (data_wr && hit_sel) begin
                irq_num_q[ldn_q] <= cfg_wdata_in[`IRQ_NUM_W-1:0];
                wake_en_q[ldn_q] <= cfg_wdata_in[`WAKE_BIT];
            end
            if (data_wr && hit_type) begin
                pol_q[ldn_q] <= cfg_wdata_in[`POL_BIT];
                lvl_q[ldn_q] <= ro_type ? ro_type_v
                                        : cfg_wdata_in[`LVL_BIT];
            end
        end
    end

    // an assertion is a rising edge of the device request
    wire bank_vec_t irq_rise = dev_irq_in & ~irq_prev_q;
    bank_vec_t assigned;
    always_comb begin
        for (int b = 0; b < `NUM_BANKS; b++) begin
            assigned[b] = irq_num_q[b] != `IRQ_NONE;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            irq_prev_q <= '0;
            event_q    <= '0;
        end else begin
            irq_prev_q <= dev_irq_in;
            event_q    <= irq_rise & wake_en_q & assigned;
        end
    end

    // line routing; lowest bank wins the type bits if software doubles up
    irq_vec_t req_d;
    irq_vec_t pol_d;
    irq_vec_t lvl_d;
    always_comb begin
        req_d = '0;
        pol_d = '0;
        lvl_d = '0;
        for (int b = `NUM_BANKS - 1; b >= 0; b--) begin
            if (assigned[b]) begin
                req_d[irq_num_q[b]] = req_d[irq_num_q[b]] | dev_irq_in[b];
                pol_d[irq_num_q[b]] = pol_q[b];
                lvl_d[irq_num_q[b]] = lvl_q[b];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            req_q      <= '0;
            pol_line_q <= '0;
            lvl_line_q <= '0;
        end else begin
            req_q      <= req_d;
            pol_line_q <= pol_d;
            lvl_line_q <= lvl_d;
        end
    end

    // reads take two cycles so memory and flop sources line up
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            hold_q     <= `ZERO_BYTE;
            from_mem_q <= 1'b0;
            rd_pend_q  <= 1'b0;
            rdata_q    <= `ZERO_BYTE;
            rvalid_q   <= 1'b0;
        end else begin
            hold_q     <= reg_rd;
            from_mem_q <= data_rd && hit_io;
            rd_pend_q  <= cfg_rd_in;
            rvalid_q   <= rd_pend_q;
            if (rd_pend_q) begin
                rdata_q <= from_mem_q ? mem_rdata : hold_q;
            end
        end
    end

    assign cfg_rdata_out       = rdata_q;
    assign cfg_rvalid_out      = rvalid_q;
    assign irq_power_event_out = event_q;
    assign irq_req_out         = req_q;
    assign irq_pol_out         = pol_line_q;
    assign irq_level_out       = lvl_line_q;
endmodule

// File: sim/ldev_cfg_chk.sv
// port checker for the logical device configuration registers
// assumes bind onto ldev_cfg_regs, one clock domain
`timescale 1ns/100ps
module ldev_cfg_chk
    import ldev_cfg_pkg::*;
(
    input wire logic                    core_clk_in,         // clock
    input wire logic                    reset_in,            // reset
    input wire logic                    cfg_wr_in,           // write strobe
    input wire logic                    cfg_rd_in,           // read strobe
    input wire logic                    cfg_rvalid_out,      // read valid
    input wire ldev_cfg_pkg::bank_vec_t dev_irq_in,          // requests
    input wire ldev_cfg_pkg::bank_vec_t irq_power_event_out, // wake pulses
    input wire ldev_cfg_pkg::irq_vec_t  irq_req_out,         // line requests
    input wire ldev_cfg_pkg::irq_vec_t  irq_pol_out,         // polarity
    input wire ldev_cfg_pkg::irq_vec_t  irq_level_out        // type
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_answer;
        ##2 cfg_rvalid_out;
    endsequence
    sequence s_silent;
        ##2 !cfg_rvalid_out;
    endsequence
    AST_RD_ANSWER: assert property (cfg_rd_in |-> s_answer)
        else $error("read not answered two cycles later");
    AST_WR_SILENT: assert property (cfg_wr_in |-> s_silent)
        else $error("write produced read valid");
    AST_NO_STRAY: assert property (cfg_rvalid_out |-> $past(cfg_rd_in, 2))
        else $error("read valid without a read");
    AST_EVT_CAUSE: assert property
        ((irq_power_event_out & ~($past(dev_irq_in) & ~$past(dev_irq_in, 2))) == '0)
        else $error("wake pulse without a request rise");
    AST_EVT_ROUTED: assert property (|irq_power_event_out |-> |irq_req_out)
        else $error("wake pulse with no routed line");
    AST_LINE0: assert property
        (!irq_req_out[0] && !irq_pol_out[0] && !irq_level_out[0])
        else $error("line zero driven");
    AST_REQ_CAUSE: assert property (|irq_req_out |-> |$past(dev_irq_in))
        else $error("line request without device request");
    AST_REQ_QUIET: assert property (dev_irq_in == '0 |=> irq_req_out == '0)
        else $error("line request stays after requests drop");
endmodule
bind ldev_cfg_regs ldev_cfg_chk ldev_cfg_chk_i (.core_clk_in, .reset_in, .cfg_wr_in,
    .cfg_rd_in, .cfg_rvalid_out, .dev_irq_in, .irq_power_event_out, .irq_req_out,
    .irq_pol_out, .irq_level_out);

// File: sim/ldev_host_model.sv
// host model driving the index-data configuration port
// assumes calls start at a rising edge; one idle cycle between strobes
`timescale 1ns/100ps
module ldev_host_model
    import ldev_cfg_pkg::*;
(
    input  wire logic                core_clk_in,   // clock
    output logic                     cfg_wr_out,    // write strobe
    output logic                     cfg_rd_out,    // read strobe
    output logic                     cfg_port_out,  // 0 index, 1 data
    output ldev_cfg_pkg::byte_t      cfg_wdata_out, // write data
    input  wire ldev_cfg_pkg::byte_t cfg_rdata_in,  // read data
    input  wire logic                cfg_rvalid_in  // read valid
);
    initial begin
        cfg_wr_out    = 1'b0;
        cfg_rd_out    = 1'b0;
        cfg_port_out  = 1'b0;
        cfg_wdata_out = 8'h00;
    end
    task automatic wr(input logic p, input byte_t d);
        @(posedge core_clk_in);
        cfg_wr_out    <= 1'b1;
        cfg_port_out  <= p;
        cfg_wdata_out <= d;
        @(posedge core_clk_in);
        cfg_wr_out    <= 1'b0;
        cfg_wdata_out <= ~d; // released bus must not keep showing the data
    endtask
    task automatic rd(input logic p, output byte_t d);
        int n;
        n = 0;
        @(posedge core_clk_in);
        cfg_rd_out   <= 1'b1;
        cfg_port_out <= p;
        @(posedge core_clk_in);
        cfg_rd_out <= 1'b0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (cfg_rvalid_in !== 1'b1 && n < 4);
        d = (cfg_rvalid_in === 1'b1) ? cfg_rdata_in : 'x;
    endtask
endmodule

// File: sim/tb.sv
// self-checking bench for the logical device configuration registers
// assumes checker and host model are compiled before it
`timescale 1ns/100ps
module tb;
    import ldev_cfg_pkg::*;
    logic      core_clk_in = 1'b0;
    logic      reset_in    = 1'b1;
    logic      wr, rd, port, rvalid;
    byte_t     wdata, rdata, v;
    bank_vec_t dev_irq     = '0;
    bank_vec_t evt;
    irq_vec_t  req, pol, lvl;
    int        miscompares = 0;
    int        tests_run   = 0;
    initial forever #2 core_clk_in = ~core_clk_in;
    ldev_cfg_regs ldev_cfg_regs_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_port_in(port), .cfg_wdata_in(wdata),
        .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .dev_irq_in(dev_irq),
        .irq_power_event_out(evt), .irq_req_out(req), .irq_pol_out(pol),
        .irq_level_out(lvl));
    ldev_host_model ldev_host_model_i (.core_clk_in(core_clk_in), .cfg_wr_out(wr),
        .cfg_rd_out(rd), .cfg_port_out(port), .cfg_wdata_out(wdata),
        .cfg_rdata_in(rdata), .cfg_rvalid_in(rvalid));
    task automatic chk(input byte_t got, input byte_t exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rst;
        reset_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        reset_in <= 1'b0;
    endtask
    task automatic wreg(input byte_t idx, input byte_t d);
        ldev_host_model_i.wr(1'b0, idx);
        ldev_host_model_i.wr(1'b1, d);
    endtask
    task automatic rc(input byte_t idx, input byte_t exp);
        ldev_host_model_i.wr(1'b0, idx);
        ldev_host_model_i.rd(1'b1, v);
        chk(v, exp);
    endtask
    // raise one device request, count wake pulses, then look at its line
    task automatic pulse(input int b, input byte_t ne, input int ln, input byte_t re);
        byte_t n;
        n = 8'h00;
        dev_irq[b] <= 1'b1;
        repeat (4) begin
            @(posedge core_clk_in);
            n = n + evt[b];
        end
        chk(n, ne);
        chk(byte_t'(req[ln]), re);
        dev_irq[b] <= 1'b0;
        @(posedge core_clk_in);
    endtask
    initial begin
        #100000;
        miscompares++;
        results();
    end
    initial begin
        rst();
        rc(8'h07, 8'h00);
        for (int i = 0; i < 4; i++) rc(8'h60 + 8'(i), 8'h00);
        rc(8'h70, 8'h00);
        rc(8'h71, 8'h02);
        ldev_host_model_i.rd(1'b0, v);
        chk(v, 8'h71);
        $display("reset values done");
        for (int b = 0; b < 9; b++) begin
            wreg(8'h07, 8'(b));
            for (int i = 0; i < 4; i++) wreg(8'h60 + 8'(i), {4'(b), 4'(i)} ^ 8'hA5);
        end
        for (int b = 0; b < 9; b++) begin
            wreg(8'h07, 8'(b));
            for (int i = 0; i < 4; i++) rc(8'h60 + 8'(i), {4'(b), 4'(i)} ^ 8'hA5);
        end
        $display("bank descriptors done");
        wreg(8'h07, 8'h09);
        wreg(8'h60, 8'hFF);
        rc(8'h60, 8'h00);
        rc(8'h74, 8'h00);
        wreg(8'h07, 8'h08);
        rc(8'h60, 8'h25);
        wreg(8'h64, 8'hAA);
        rc(8'h64, 8'h00);
        rc(8'h74, 8'h04);
        rc(8'h75, 8'h04);
        $display("unimplemented places done");
        wreg(8'h07, 8'h02);
        wreg(8'h70, 8'hFF);
        rc(8'h70, 8'h1F);
        wreg(8'h71, 8'hFF);
        rc(8'h71, 8'h03);
        wreg(8'h70, 8'h15);
        for (int t = 0; t < 4; t++) begin
            wreg(8'h71, 8'(t));
            repeat (2) @(posedge core_clk_in);
            chk(pol[7:0], {2'b00, 1'(t >> 1), 5'h00});
            chk(lvl[7:0], {2'b00, 1'(t), 5'h00});
        end
        pulse(2, 8'h01, 5, 8'h01);
        // read-modify-write of the interrupt select: point the index at it first
        ldev_host_model_i.wr(1'b0, 8'h70);
        ldev_host_model_i.rd(1'b1, v);
        chk(v, 8'h15);
        wreg(8'h70, v & 8'hEF);
        pulse(2, 8'h00, 5, 8'h01);
        wreg(8'h70, 8'h10);
        pulse(2, 8'h00, 5, 8'h00);
        wreg(8'h07, 8'h03);
        wreg(8'h70, 8'h16);
        pulse(3, 8'h01, 6, 8'h01);
        $display("interrupt routing done");
        rst();
        rc(8'h70, 8'h00);
        rc(8'h71, 8'h02);
        chk(pol[7:0] | lvl[7:0], 8'h00);
        $display("second reset done");
        results();
    end
endmodule
